// ===== rtl/rml_mode_led.sv
// Navigation-mode tracker with green fix and orange RTK indicators.
// Assumes status inputs come from logic on sys_clk (satellite counts already
// restricted to satellites the base also sees); the response byte strobe too.
// Function
// - Exactly one of three modes held
// - Green steady before fix, blinking after
// - Correction stream enters float mode
// - Orange blinks while in float
// - Stream loss returns standalone, orange off
// - Resolved ambiguity enters fixed, orange steady
// - Single constellation needs six locked satellites
// - GPS plus BeiDou: three BeiDou, eight total
// - GPS plus GLONASS: two GLONASS, seven total
// - Lost lock drops fixed to float
// - Recovered signals re-enter fixed mode
// - Only satellites common with base count
// - Raw output needs bit sync and week time
// - Leap correction applied once clock accurate and info acquired
// - Response byte 18 equal 07 means valid
`timescale 1ns/1ps
module rml_mode_led
    import rml_pkg::*;
#(
    parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire rml_status_t status_in,
    input wire logic rsp_byte_valid,
    input wire logic [4:0] rsp_byte_index,
    input wire logic [7:0] rsp_byte,
    output rml_out_t out,
    output rml_mode_t mode
);

    typedef struct packed {
        rml_status_t st;
        rml_mode_t mode;
        logic [CNT_W-1:0] blink_cnt;
        logic blink;
        logic leap_done;
        logic time_valid;
        rml_out_t out;
    } rml_state_t;

    rml_state_t cur;
    rml_state_t next_cur;

    // Common-satellite count test per constellation combination
    function automatic logic enough_sats(input rml_status_t s);
        logic [6:0] total;
        total = 7'(s.common_gps) + 7'(s.common_bds) + 7'(s.common_glo);
        enough_sats = 1'b0;
        case (s.combo)
            RML_CONST_GPS_BDS: begin
                enough_sats = (s.common_bds >= MIN_BDS_SATS) && (total >= 7'(MIN_BDS_TOTAL));
            end
            RML_CONST_GPS_GLO: begin
                enough_sats = (s.common_glo >= MIN_GLO_SATS) && (total >= 7'(MIN_GLO_TOTAL));
            end
            default: begin
                enough_sats = total >= 7'(MIN_SINGLE);
            end
        endcase
    endfunction

    logic can_fix;
    assign can_fix = cur.st.amb_resolved && cur.st.phase_lock && enough_sats(cur.st);

    always_comb begin
        next_cur = cur;
        next_cur.st = status_in;

        if (cur.blink_cnt >= CNT_W'(BLINK_HALF - 1)) begin
            next_cur.blink_cnt = '0;
            next_cur.blink = ~cur.blink;
        end else begin
            next_cur.blink_cnt = cur.blink_cnt + 1'b1;
        end

        case (cur.mode)
            RML_STANDALONE: begin
                if (cur.st.corr_present) begin
                    next_cur.mode = RML_FLOAT;
                end
            end
            RML_FLOAT: begin
                if (!cur.st.corr_present) begin
                    next_cur.mode = RML_STANDALONE;
                end else if (can_fix) begin
                    next_cur.mode = RML_FIXED;
                end
            end
            RML_FIXED: begin
                if (!cur.st.corr_present) begin
                    next_cur.mode = RML_STANDALONE;
                end else if (!can_fix) begin
                    next_cur.mode = RML_FLOAT;
                end
            end
            default: begin
                next_cur.mode = RML_STANDALONE;
            end
        endcase

        if (cur.st.clock_accurate && cur.st.leap_info) begin
            next_cur.leap_done = 1'b1;
        end

        // flag byte check; frame is framed upstream
        if (rsp_byte_valid && rsp_byte_index == TIME_FLAG_POS) begin
            next_cur.time_valid = (rsp_byte == TIME_FLAG_OK);
        end

        next_cur.out.green_led = cur.st.fix_valid ? cur.blink : 1'b1;
        case (cur.mode)
            RML_FLOAT: next_cur.out.orange_led = cur.blink;
            RML_FIXED: next_cur.out.orange_led = 1'b1;
            default: next_cur.out.orange_led = 1'b0;
        endcase
        next_cur.out.rtk_fixed = (cur.mode == RML_FIXED);
        next_cur.out.rtk_float = (cur.mode == RML_FLOAT);
        next_cur.out.raw_enable = cur.st.bit_sync && cur.st.tow_valid;
        next_cur.out.leap_apply = cur.leap_done;
        next_cur.out.time_valid = cur.time_valid;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            // All-zero state is standalone mode, indicators dark, sticky flags clear
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign out = cur.out;
    assign mode = cur.mode;

    AST_LOSS_STANDALONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.mode != RML_STANDALONE && !cur.st.corr_present |=> mode == RML_STANDALONE)
        else $error("stream loss did not return to standalone");
    AST_ENTER_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.mode == RML_STANDALONE && cur.st.corr_present |=> mode == RML_FLOAT)
        else $error("stream did not enter float");
    AST_ENTER_FIXED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.mode == RML_FLOAT && cur.st.corr_present && can_fix |=> mode == RML_FIXED)
        else $error("resolved ambiguity did not enter fixed");
    AST_DROP_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.mode == RML_FIXED && cur.st.corr_present && !can_fix |=> mode == RML_FLOAT)
        else $error("lock loss did not drop to float");
    AST_FIXED_NEEDS_SATS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(mode == RML_FIXED) |-> $past(can_fix))
        else $error("fixed entered without enough satellites");
    AST_ORANGE_FIXED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_FIXED ##1 mode == RML_FIXED |-> out.orange_led)
        else $error("orange not steady in fixed");
    AST_ORANGE_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_STANDALONE ##1 mode == RML_STANDALONE |-> !out.orange_led)
        else $error("orange lit in standalone");
    AST_GREEN_STEADY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !cur.st.fix_valid |=> out.green_led)
        else $error("green not steady without fix");
    AST_RAW_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        out.raw_enable |-> $past(cur.st.bit_sync && cur.st.tow_valid))
        else $error("raw output without sync and week time");
    AST_TIME_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rsp_byte_valid && rsp_byte_index == TIME_FLAG_POS && rsp_byte != TIME_FLAG_OK
        |=> ##1 !out.time_valid)
        else $error("time flagged valid on wrong byte value");

    AST_TIME_OK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rsp_byte_valid && rsp_byte_index == TIME_FLAG_POS && rsp_byte == TIME_FLAG_OK
        |=> ##1 out.time_valid)
        else $error("time not flagged valid on good byte");

    AST_TIME_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(rsp_byte_valid && rsp_byte_index == TIME_FLAG_POS) |=> $stable(cur.time_valid))
        else $error("time flag changed without flag byte");

    AST_ONE_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(out.rtk_fixed && out.rtk_float))
        else $error("float and fixed flagged together");

    AST_FIXED_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_FIXED |=> out.rtk_fixed)
        else $error("fixed flag missing in fixed mode");

    AST_FLOAT_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_FLOAT |=> out.rtk_float)
        else $error("float flag missing in float mode");

    AST_NO_JUMP_FIXED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_STANDALONE |=> mode != RML_FIXED)
        else $error("fixed entered straight from standalone");

    AST_STAY_STANDALONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_STANDALONE && !cur.st.corr_present |=> mode == RML_STANDALONE)
        else $error("left standalone without corrections");

    AST_FLOAT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_FLOAT && cur.st.corr_present && !can_fix |=> mode == RML_FLOAT)
        else $error("float left while still unresolved");

    AST_FIXED_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_FIXED && cur.st.corr_present && can_fix |=> mode == RML_FIXED)
        else $error("fixed left while still resolved");

    AST_ORANGE_BLINK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_FLOAT |=> out.orange_led == $past(cur.blink))
        else $error("orange not following blink in float");

    AST_GREEN_BLINK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.st.fix_valid |=> out.green_led == $past(cur.blink))
        else $error("green not following blink with fix");

    AST_BLINK_TOGGLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.blink_cnt >= CNT_W'(BLINK_HALF - 1) |=> cur.blink != $past(cur.blink))
        else $error("blink phase did not toggle");

    AST_BLINK_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.blink_cnt < CNT_W'(BLINK_HALF - 1) |=> $stable(cur.blink))
        else $error("blink phase toggled early");

    AST_LEAP_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        out.leap_apply |=> out.leap_apply)
        else $error("leap correction flag dropped");

    AST_LEAP_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.st.clock_accurate && cur.st.leap_info |=> ##1 out.leap_apply)
        else $error("leap correction not applied");

    AST_RAW_ON: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.st.bit_sync && cur.st.tow_valid |=> out.raw_enable)
        else $error("raw output withheld with sync and week time");

    AST_FIXED_NEEDS_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(mode == RML_FIXED) |-> $past(cur.st.phase_lock && cur.st.amb_resolved))
        else $error("fixed entered without lock and resolution");

    AST_BDS_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.st.combo == RML_CONST_GPS_BDS && cur.st.common_bds < MIN_BDS_SATS
        |=> !(mode == RML_FIXED && $past(mode) != RML_FIXED))
        else $error("fixed entered with too few BeiDou satellites");

    AST_GLO_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.st.combo == RML_CONST_GPS_GLO && cur.st.common_glo < MIN_GLO_SATS
        |=> !(mode == RML_FIXED && $past(mode) != RML_FIXED))
        else $error("fixed entered with too few GLONASS satellites");

    AST_SINGLE_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cur.st.combo == RML_CONST_SINGLE
        && 7'(cur.st.common_gps) + 7'(cur.st.common_bds) + 7'(cur.st.common_glo) < 7'(MIN_SINGLE)
        |=> !(mode == RML_FIXED && $past(mode) != RML_FIXED))
        else $error("fixed entered with too few satellites");

    AST_COUNT_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == RML_FIXED |-> $past(can_fix))
        else $error("fixed held without enough common satellites");

endmodule

// ===== rtl/rml_pkg.sv
// Package for the navigation-mode tracker and status indicator block.
// Assumes one 100 MHz system clock; all values here are shared constants and types.
package rml_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;
    // Blink half period in milliseconds; the count is derived from the clock rate
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
    localparam int unsigned CNT_W = 32;

    localparam logic [5:0] MIN_SINGLE = 6'h06;
    localparam logic [5:0] MIN_BDS_SATS = 6'h03;
    localparam logic [5:0] MIN_BDS_TOTAL = 6'h08;
    localparam logic [5:0] MIN_GLO_SATS = 6'h02;
    localparam logic [5:0] MIN_GLO_TOTAL = 6'h07;
    localparam logic [7:0] ELEV_MASK_DEF = 8'h0A;

    // Time query response: flag byte index and value meaning time is correct
    localparam logic [4:0] TIME_FLAG_POS = 5'h12;
    localparam logic [7:0] TIME_FLAG_OK = 8'h07;
    localparam logic [7:0] QUERY_SYNC1 = 8'hB5;
    localparam logic [7:0] QUERY_SYNC2 = 8'h62;
    localparam logic [7:0] QUERY_CLASS = 8'h01;
    localparam logic [7:0] QUERY_ID = 8'h20;

    typedef enum logic [1:0] {
        RML_CONST_SINGLE,
        RML_CONST_GPS_BDS,
        RML_CONST_GPS_GLO
    } rml_const_t;

    typedef enum {
        RML_STANDALONE,
        RML_FLOAT,
        RML_FIXED
    } rml_mode_t;

    typedef struct packed {
        logic fix_valid;
        logic corr_present;
        logic amb_resolved;
        logic phase_lock;
        logic bit_sync;
        logic tow_valid;
        logic clock_accurate;
        logic leap_info;
        rml_const_t combo;
        logic [5:0] common_gps;
        logic [5:0] common_bds;
        logic [5:0] common_glo;
    } rml_status_t;

    typedef struct packed {
        logic green_led;
        logic orange_led;
        logic rtk_fixed;
        logic rtk_float;
        logic raw_enable;
        logic leap_apply;
        logic time_valid;
    } rml_out_t;

endpackage

// ===== verif/rml_host_model.sv
// Host side: plays back a time query response one byte per clock.
// Assumes the bench calls send_rsp; bytes change at the falling edge.
`timescale 1ns/1ps
module rml_host_model
    import rml_pkg::*;
(
    input wire logic sys_clk,
    output logic rsp_byte_valid,
    output logic [4:0] rsp_byte_index,
    output logic [7:0] rsp_byte
);
    initial begin
        rsp_byte_valid = 1'b0;
        rsp_byte_index = 5'h00;
        rsp_byte = 8'h00;
    end
    task automatic send_rsp(input logic [7:0] flag);
        for (int k = 0; k < 24; k++) begin
            @(negedge sys_clk);
            rsp_byte_valid = 1'b1;
            rsp_byte_index = 5'(k);
            rsp_byte = (k == 0) ? QUERY_SYNC1 : (k == 1) ? QUERY_SYNC2 : 8'(k * 8'h25);
            if (5'(k) == TIME_FLAG_POS) begin
                rsp_byte = flag;
            end
        end
        @(negedge sys_clk);
        rsp_byte_valid = 1'b0;
        // Idle byte flips so a stale value is never mistaken for data
        rsp_byte = ~rsp_byte;
    endtask
endmodule

// ===== verif/test_rtk_mode_led_status.sv
// Self-checking bench for the mode tracker and indicators.
// Assumes a 100 MHz clock and a short blink count of 4 cycles.
`timescale 1ns/1ps
module test_rtk_mode_led_status;
    import rml_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    rml_status_t st = '0;
    logic rv;
    logic [4:0] ri;
    logic [7:0] rb;
    rml_out_t out;
    rml_mode_t mode;
    int n_errors = 0;
    int compares = 0;
    int c;
    logic [31:0] seed = 32'h8627;
    logic [31:0] r;
    logic leap = 1'b0;
    logic ef;
    always #5 sys_clk = ~sys_clk;
    rml_mode_led #(.BLINK_HALF(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .status_in(st),
        .rsp_byte_valid(rv), .rsp_byte_index(ri), .rsp_byte(rb), .out(out), .mode(mode));
    rml_host_model host (.sys_clk(sys_clk), .rsp_byte_valid(rv), .rsp_byte_index(ri),
        .rsp_byte(rb));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic fix_ok(rml_status_t s);
        if (s.combo == RML_CONST_GPS_BDS) begin
            return s.common_bds >= MIN_BDS_SATS && s.common_gps + s.common_bds >= MIN_BDS_TOTAL;
        end
        if (s.combo == RML_CONST_GPS_GLO) begin
            return s.common_glo >= MIN_GLO_SATS && s.common_gps + s.common_glo >= MIN_GLO_TOTAL;
        end
        return s.common_gps + s.common_bds + s.common_glo >= MIN_SINGLE;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (6) @(negedge sys_clk);
    endtask
    // Counts lit samples over 20 cycles: 20 steady, 0 off, between means blinking
    task automatic lit(input bit g, output int n);
        n = 0;
        repeat (20) begin
            @(negedge sys_clk);
            n += ((g ? out.green_led : out.orange_led) === 1'b1);
        end
    endtask
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        settle();
        chk(32'(mode), 32'(RML_STANDALONE));
        lit(1'b1, c);
        chk(c, 20);
        st.fix_valid = 1'b1;
        settle();
        lit(1'b1, c);
        chk(32'(c > 0 && c < 20), 1);
        st.corr_present = 1'b1;
        settle();
        chk(32'(mode), 32'(RML_FLOAT));
        lit(1'b0, c);
        chk(32'(c > 0 && c < 20), 1);
        for (int i = 0; i < 40; i++) begin
            r = xs();
            st.combo = rml_const_t'(2'(r % 3));
            st.common_gps = 6'(r[7:4] % 10);
            st.common_bds = (st.combo == RML_CONST_GPS_GLO) ? 6'h00 : 6'(r[11:8] % 6);
            st.common_glo = (st.combo == RML_CONST_GPS_BDS) ? 6'h00 : 6'(r[15:12] % 6);
            st.amb_resolved = r[22] | r[23];
            st.phase_lock = r[16] | r[17];
            {st.bit_sync, st.tow_valid, st.clock_accurate, st.leap_info} = r[21:18];
            if (i < 2) begin
                st.combo = i ? RML_CONST_GPS_BDS : RML_CONST_SINGLE;
                {st.common_gps, st.common_bds, st.common_glo} = {6'h04, 6'h01, 6'h01};
                st.amb_resolved = 1'b1;
            end
            settle();
            ef = fix_ok(st) && st.phase_lock && st.amb_resolved;
            leap |= st.clock_accurate & st.leap_info;
            chk(32'(mode), ef ? 32'(RML_FIXED) : 32'(RML_FLOAT));
            chk({out.rtk_fixed, out.rtk_float}, {ef, !ef});
            chk(out.raw_enable, st.bit_sync & st.tow_valid);
            chk(out.leap_apply, leap);
            if (ef) begin
                lit(1'b0, c);
                chk(c, 20);
            end
        end
        st.combo = RML_CONST_SINGLE;
        st.phase_lock = 1'b1;
        st.common_gps = 6'h06;
        settle();
        st.corr_present = 1'b0;
        settle();
        chk(32'(mode), 32'(RML_STANDALONE));
        lit(1'b0, c);
        chk(c, 0);
        host.send_rsp(TIME_FLAG_OK);
        settle();
        chk(out.time_valid, 1'b1);
        host.send_rsp(8'h03);
        settle();
        chk(out.time_valid, 1'b0);
        end_of_test();
    end
endmodule
